// >>> rtl/octal_liu_alarm_waveform_regs.sv
// Host register bank: driver high-Z, alarm status and interrupt, waveform sample access
//
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/100ps
// Operation
// - Bit n set puts channel n transmit driver in high impedance.
// - Control, status, flag, mask and pointer registers clear on power-up and reset.
// - Live alarm status bit n follows channel n alarm detection.
// - A status change is captured and interrupts only when its enable bit is set.
// - Any enabled change of status bit n, either direction, sets change flag n.
// - Change flags stay set and accumulate until the interrupt is cleared.
// - Reading the change flags clears them and releases the active-low interrupt.
// - Disabling an interrupt leaves the live status tracking the condition.
// - A sample write goes at once to every channel whose broadcast bit is set.
// - Pointer bits 7:5 select the target channel 0 to 7.
// - Pointer bits 4:0 select the sample location within the channel.
// - Sample port writes store at, and reads return, the pointed location.
// - Samples are seven-bit two's complement values.
// - Samples clear only at power-up; software reset leaves them intact.
module octal_liu_alarm_waveform_regs (
	// Clock and power-up reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Avalon-MM slave
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// Receiver alarm detection per channel
	input  wire logic [7:0]  alarmDetect,
	// Line side controls and host interrupt
	output logic      [7:0]  txDriverHighZ,
	output logic             irqN
);
	typedef struct packed {
		liu_regs_pkg::bus_state_e               phase;
		logic [liu_regs_pkg::REG_W-1:0]     txDisable;
		logic [liu_regs_pkg::REG_W-1:0]     liveStatus;
		logic [liu_regs_pkg::REG_W-1:0]     irqMask;
		logic [liu_regs_pkg::REG_W-1:0]     changeFlags;
		logic [liu_regs_pkg::REG_W-1:0]     bcastMask;
		logic [liu_regs_pkg::REG_W-1:0]     samplePtr;
		logic [liu_regs_pkg::REG_W-1:0]     readData;
		logic [liu_regs_pkg::SAMPLE_AW-1:0] clearIdx;
	} regs_s;

	regs_s                                                  st;
	regs_s                                                  next_st;
	logic [liu_regs_pkg::IDX_W-1:0]                         idx;
	logic                                                   wrHit;
	logic                                                   respond;
	logic                                                   flagRead;
	logic                                                   softReset;
	logic                                                   phaseWrite;
	logic [liu_regs_pkg::REG_W-1:0]                         captured;
	logic [liu_regs_pkg::REG_W-1:0]                         clearBits;
	logic [liu_regs_pkg::REG_W-1:0]                         wrByte;
	logic [liu_regs_pkg::CH_AW-1:0]                         targetCh;
	logic [liu_regs_pkg::SAMPLE_AW-1:0]                     sampleAddr;
	logic [liu_regs_pkg::NUM_CH-1:0]                        laneWrEn;
	logic [liu_regs_pkg::SAMPLE_AW-1:0]                     memWrAddr;
	logic [liu_regs_pkg::SAMPLE_W-1:0]                      memWrData;
	logic [liu_regs_pkg::NUM_CH*liu_regs_pkg::SAMPLE_W-1:0] memRdData;
	logic [liu_regs_pkg::SAMPLE_W-1:0]                      laneRd;
	logic [liu_regs_pkg::REG_W-1:0]                         readMux;

	assign idx        = avs_address[7:2];
	assign wrByte     = avs_writedata[7:0];
	assign wrHit      = (st.phase == liu_regs_pkg::ST_IDLE) && avs_write && avs_byteenable[0];
	assign respond    = (st.phase == liu_regs_pkg::ST_RESPOND);
	assign flagRead   = respond && (idx == liu_regs_pkg::IDX_ALARM_CHANGE_FLAGS);
	assign softReset  = wrHit && (idx == liu_regs_pkg::IDX_SOFT_RESET)
		&& wrByte[liu_regs_pkg::SOFT_RESET_BIT];
	assign phaseWrite = wrHit && (idx == liu_regs_pkg::IDX_WAVE_SAMPLE_PORT);
	assign targetCh   = st.samplePtr[7:liu_regs_pkg::PTR_CH_LSB];
	assign sampleAddr = st.samplePtr[liu_regs_pkg::PTR_CH_LSB-1:liu_regs_pkg::PTR_SAMPLE_LSB];

	// Edge of each channel's alarm level, gated by its enable
	assign captured = (alarmDetect ^ st.liveStatus) & st.irqMask;

	// Only the bits actually returned are cleared, so a change arriving between
	// fetch and response is not lost
	assign clearBits = (flagRead ? st.readData : liu_regs_pkg::RST_REG)
		| ((wrHit && (idx == liu_regs_pkg::IDX_ALARM_FLAG_CLEAR)) ? wrByte
		: liu_regs_pkg::RST_REG);

	// Sample store write port: power-up sweep, then host writes
	always_comb begin
		laneWrEn  = '0;
		memWrAddr = sampleAddr;
		memWrData = wrByte[liu_regs_pkg::SAMPLE_W-1:0];
		if (st.phase == liu_regs_pkg::ST_CLEAR) begin
			laneWrEn  = '1;
			memWrAddr = st.clearIdx;
			memWrData = liu_regs_pkg::RST_SAMPLE;
		end else if (phaseWrite) begin
			if (st.bcastMask != liu_regs_pkg::RST_REG) begin
				laneWrEn = st.bcastMask;
			end else begin
				laneWrEn = liu_regs_pkg::NUM_CH'(1) << targetCh;
			end
		end
	end

	waveform_sample_mem u_sample_mem (
		.clk    (clk),
		.wrEn   (laneWrEn),
		.wrAddr (memWrAddr),
		.wrData (memWrData),
		.rdAddr (sampleAddr),
		.rdData (memRdData)
	);

	assign laneRd = memRdData[targetCh*liu_regs_pkg::SAMPLE_W +: liu_regs_pkg::SAMPLE_W];

	// Read data for the addressed register; unmapped and write-only read as zero
	always_comb begin
		case (idx)
			liu_regs_pkg::IDX_TX_HIGHZ_CTRL:      readMux = st.txDisable;
			liu_regs_pkg::IDX_ALARM_LIVE_STATUS:  readMux = st.liveStatus;
			liu_regs_pkg::IDX_ALARM_IRQ_MASK:     readMux = st.irqMask;
			liu_regs_pkg::IDX_ALARM_CHANGE_FLAGS: readMux = st.changeFlags;
			liu_regs_pkg::IDX_WAVE_BCAST_MASK:    readMux = st.bcastMask;
			liu_regs_pkg::IDX_WAVE_SAMPLE_PTR:    readMux = st.samplePtr;
			liu_regs_pkg::IDX_WAVE_SAMPLE_PORT:   readMux = {1'b0, laneRd};
			default:                              readMux = liu_regs_pkg::RST_REG;
		endcase
	end

	always_comb begin
		next_st             = st;
		next_st.liveStatus  = alarmDetect;
		next_st.changeFlags = (st.changeFlags & ~clearBits) | captured;
		case (st.phase)
			liu_regs_pkg::ST_CLEAR: begin
				next_st.clearIdx = st.clearIdx + 5'h01;
				if (st.clearIdx == 5'h1f) begin
					next_st.phase = liu_regs_pkg::ST_IDLE;
				end
			end
			liu_regs_pkg::ST_IDLE: begin
				if (avs_read) begin
					next_st.phase = liu_regs_pkg::ST_FETCH;
				end else if (wrHit) begin
					case (idx)
						liu_regs_pkg::IDX_TX_HIGHZ_CTRL:   next_st.txDisable = wrByte;
						liu_regs_pkg::IDX_ALARM_IRQ_MASK:  next_st.irqMask   = wrByte;
						liu_regs_pkg::IDX_WAVE_BCAST_MASK: next_st.bcastMask = wrByte;
						liu_regs_pkg::IDX_WAVE_SAMPLE_PTR: next_st.samplePtr = wrByte;
						default: begin
						end
					endcase
				end
			end
			liu_regs_pkg::ST_FETCH: begin
				next_st.readData = readMux;
				next_st.phase    = liu_regs_pkg::ST_RESPOND;
			end
			liu_regs_pkg::ST_RESPOND: begin
				next_st.phase = liu_regs_pkg::ST_IDLE;
			end
			default: begin
				next_st.phase = liu_regs_pkg::ST_IDLE;
			end
		endcase
		// Software reset spares the sample store and the bus sequencer
		if (softReset) begin
			next_st.txDisable   = liu_regs_pkg::RST_REG;
			next_st.liveStatus  = liu_regs_pkg::RST_REG;
			next_st.irqMask     = liu_regs_pkg::RST_REG;
			next_st.changeFlags = liu_regs_pkg::RST_REG;
			next_st.bcastMask   = liu_regs_pkg::RST_REG;
			next_st.samplePtr   = liu_regs_pkg::RST_REG;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st.phase       <= liu_regs_pkg::ST_CLEAR;
			st.txDisable   <= liu_regs_pkg::RST_REG;
			st.liveStatus  <= liu_regs_pkg::RST_REG;
			st.irqMask     <= liu_regs_pkg::RST_REG;
			st.changeFlags <= liu_regs_pkg::RST_REG;
			st.bcastMask   <= liu_regs_pkg::RST_REG;
			st.samplePtr   <= liu_regs_pkg::RST_REG;
			st.readData    <= liu_regs_pkg::RST_REG;
			st.clearIdx    <= '0;
		end else begin
			st <= next_st;
		end
	end

	// Writes finish in their first idle cycle; reads wait through the idle request cycle and a fetch cycle first
	always_comb begin
		case (st.phase)
			liu_regs_pkg::ST_IDLE:    avs_waitrequest = avs_read;
			liu_regs_pkg::ST_RESPOND: avs_waitrequest = 1'b0;
			default:                  avs_waitrequest = 1'b1;
		endcase
	end

	assign avs_readdata  = {24'h000000, st.readData};
	assign txDriverHighZ = st.txDisable;
	assign irqN          = ~|(st.changeFlags & st.irqMask);

	property p_highz_write;
		@(posedge clk) disable iff (!rst_n)
		(wrHit && idx == liu_regs_pkg::IDX_TX_HIGHZ_CTRL && !avs_waitrequest)
			|=> (txDriverHighZ == $past(avs_writedata[7:0]));
	endproperty
	a_highz_write: assert property (p_highz_write) else $error("high-Z control not written");

	property p_soft_reset_clears;
		@(posedge clk) disable iff (!rst_n)
		softReset |=> (st.txDisable == 8'h00 && st.irqMask == 8'h00 && st.changeFlags == 8'h00
			&& st.bcastMask == 8'h00 && st.samplePtr == 8'h00 && irqN);
	endproperty
	a_soft_reset_clears: assert property (p_soft_reset_clears) else $error("reset left state");

	property p_live_status;
		@(posedge clk) disable iff (!rst_n)
		(rst_n && !softReset) |=> (st.liveStatus == $past(alarmDetect));
	endproperty
	a_live_status: assert property (p_live_status) else $error("live status stale");

	property p_masked_no_capture;
		@(posedge clk) disable iff (!rst_n)
		1'b1 |=> ((st.changeFlags & ~$past(st.changeFlags) & ~$past(st.irqMask)) == 8'h00);
	endproperty
	a_masked_no_capture: assert property (p_masked_no_capture) else $error("masked flag set");

	property p_change_sets_flag;
		@(posedge clk) disable iff (!rst_n)
		(captured != 8'h00 && !softReset) |=> ((st.changeFlags & $past(captured)) == $past(captured));
	endproperty
	a_change_sets_flag: assert property (p_change_sets_flag) else $error("change not flagged");

	property p_flags_sticky;
		@(posedge clk) disable iff (!rst_n)
		!softReset |=> (($past(st.changeFlags) & ~$past(clearBits) & ~st.changeFlags) == 8'h00);
	endproperty
	a_flags_sticky: assert property (p_flags_sticky) else $error("flag dropped early");

	property p_read_clears;
		@(posedge clk) disable iff (!rst_n)
		(flagRead && captured == 8'h00 && st.readData == st.changeFlags && !softReset)
			|=> (st.changeFlags == 8'h00 && irqN);
	endproperty
	a_read_clears: assert property (p_read_clears) else $error("read did not clear");

	property p_disabled_still_live;
		@(posedge clk) disable iff (!rst_n)
		(st.irqMask == 8'h00 && !softReset) ##1 !softReset |=> (st.liveStatus == $past(alarmDetect));
	endproperty
	a_disabled_still_live: assert property (p_disabled_still_live) else $error("status frozen");

	property p_broadcast_lanes;
		@(posedge clk) disable iff (!rst_n)
		(phaseWrite && st.bcastMask != 8'h00) |-> (laneWrEn == st.bcastMask);
	endproperty
	a_broadcast_lanes: assert property (p_broadcast_lanes) else $error("broadcast lanes wrong");

	property p_single_lane;
		@(posedge clk) disable iff (!rst_n)
		(phaseWrite && st.bcastMask == 8'h00) |-> (laneWrEn == (8'h01 << st.samplePtr[7:5]));
	endproperty
	a_single_lane: assert property (p_single_lane) else $error("target lane wrong");

	property p_sample_top_zero;
		@(posedge clk) disable iff (!rst_n)
		(respond && idx == liu_regs_pkg::IDX_WAVE_SAMPLE_PORT) |-> (avs_readdata[31:7] == 25'h0);
	endproperty
	a_sample_top_zero: assert property (p_sample_top_zero) else $error("sample top bit set");

	property p_soft_reset_keeps_store;
		@(posedge clk) disable iff (!rst_n)
		softReset |=> (st.phase == liu_regs_pkg::ST_IDLE && laneWrEn == 8'h00);
	endproperty
	a_soft_reset_keeps_store: assert property (p_soft_reset_keeps_store) else $error("store swept");
endmodule

// >>> rtl/liu_regs_pkg.sv
// Register map, field layout and bus sequencer states of the line interface register bank
package liu_regs_pkg;
	localparam int NUM_CH      = 8;
	localparam int SAMPLE_W    = 7;
	localparam int NUM_SAMPLES = 32;
	localparam int SAMPLE_AW   = 5;
	localparam int CH_AW       = 3;
	localparam int REG_W       = 8;
	localparam int IDX_W       = 6;

	// Register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_TX_HIGHZ_CTRL      = 6'h12;
	localparam logic [IDX_W-1:0] IDX_ALARM_LIVE_STATUS  = 6'h13;
	localparam logic [IDX_W-1:0] IDX_ALARM_IRQ_MASK     = 6'h14;
	localparam logic [IDX_W-1:0] IDX_ALARM_CHANGE_FLAGS = 6'h15;
	localparam logic [IDX_W-1:0] IDX_WAVE_BCAST_MASK    = 6'h16;
	localparam logic [IDX_W-1:0] IDX_WAVE_SAMPLE_PTR    = 6'h17;
	localparam logic [IDX_W-1:0] IDX_WAVE_SAMPLE_PORT   = 6'h18;
	localparam logic [IDX_W-1:0] IDX_ALARM_FLAG_CLEAR   = 6'h20;
	localparam logic [IDX_W-1:0] IDX_SOFT_RESET         = 6'h21;

	// Field positions
	localparam int PTR_CH_LSB      = 5;
	localparam int PTR_SAMPLE_LSB  = 0;
	localparam int SOFT_RESET_BIT  = 0;
	localparam int PHASE_RSVD_BIT  = 7;

	// Reset values
	localparam logic [REG_W-1:0]    RST_REG    = 8'h00;
	localparam logic [SAMPLE_W-1:0] RST_SAMPLE = 7'h00;

	typedef enum logic [1:0] {
		ST_CLEAR,
		ST_IDLE,
		ST_FETCH,
		ST_RESPOND
	} bus_state_e;
endpackage

// >>> rtl/waveform_sample_mem.sv
// Phase sample store: one word per sample address, one seven-bit lane per channel
`timescale 1ns/100ps
module waveform_sample_mem (
	// Clock
	input  wire logic                                                   clk,
	// Write side, per-lane enables allow broadcast writes
	input  wire logic [liu_regs_pkg::NUM_CH-1:0]                        wrEn,
	input  wire logic [liu_regs_pkg::SAMPLE_AW-1:0]                     wrAddr,
	input  wire logic [liu_regs_pkg::SAMPLE_W-1:0]                      wrData,
	// Read side, registered
	input  wire logic [liu_regs_pkg::SAMPLE_AW-1:0]                     rdAddr,
	output logic      [liu_regs_pkg::NUM_CH*liu_regs_pkg::SAMPLE_W-1:0] rdData
);
	localparam int WORD_W = liu_regs_pkg::NUM_CH * liu_regs_pkg::SAMPLE_W;

	typedef struct packed {
		logic [liu_regs_pkg::NUM_SAMPLES-1:0][WORD_W-1:0] cells;
		logic [WORD_W-1:0]                                rdWord;
	} mem_s;

	mem_s              st;
	mem_s              next_st;
	logic [WORD_W-1:0] mergedWord;

	// Lanes not enabled keep their old contents
	genvar lane;
	generate
		for (lane = 0; lane < liu_regs_pkg::NUM_CH; lane++) begin : g_lane
			assign mergedWord[lane*liu_regs_pkg::SAMPLE_W +: liu_regs_pkg::SAMPLE_W] =
				wrEn[lane] ? wrData
				: st.cells[wrAddr][lane*liu_regs_pkg::SAMPLE_W +: liu_regs_pkg::SAMPLE_W];
		end
	endgenerate

	always_comb begin
		next_st = st;
		if (|wrEn) begin
			next_st.cells[wrAddr] = mergedWord;
		end
		next_st.rdWord = st.cells[rdAddr];
	end

	// No reset here: the owner sweeps zeros in after power-up
	always_ff @(posedge clk) begin
		st <= next_st;
	end

	assign rdData = st.rdWord;
endmodule

// >>> testbench/octal_liu_alarm_waveform_regs_tb_top.sv
// Self-checking bench for the line interface register bank
`timescale 1ns/100ps
module octal_liu_alarm_waveform_regs_tb_top;
	logic        clk;
	logic        rst_n;
	logic [7:0]  addr;
	logic        rd;
	logic        wr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic        waitReq;
	logic [7:0]  alarmDetect;
	logic [7:0]  txDriverHighZ;
	logic        irqN;
	int          fails;
	int          check_count;

	octal_liu_alarm_waveform_regs i_dut (
		.clk             (clk),
		.rst_n           (rst_n),
		.avs_address     (addr),
		.avs_read        (rd),
		.avs_write       (wr),
		.avs_writedata   (wdata),
		.avs_byteenable  (4'h1),
		.avs_readdata    (rdata),
		.avs_waitrequest (waitReq),
		.alarmDetect     (alarmDetect),
		.txDriverHighZ   (txDriverHighZ),
		.irqN            (irqN)
	);

	always #20 clk = ~clk;

	task automatic stop_test();
		$display("Counts: %0d comparisons, %0d mismatches", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] act, input logic [31:0] exp, input string what);
		check_count++;
		if (act !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, act, exp);
		end
	endtask

	// One Avalon transfer; waitrequest and read data are taken at the rising edge itself
	task automatic bus(input logic isRd, input logic [7:0] a, input logic [7:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		q = 32'h0;
		@(posedge clk);
		rd <= isRd;
		wr <= !isRd;
		addr <= a;
		wdata <= {24'h0, d};
		do begin
			@(posedge clk);
			n++;
			if (n > 200) begin
				fails++;
				$display("CHECK FAILED at %0t: bus wait timed out", $time);
				stop_test();
			end
		end while (waitReq !== 1'b0);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b0, a, d, q);
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		logic [31:0] q;
		bus(1'b1, a, 8'h00, q);
		chk(q, {24'h0, exp}, $sformatf("read of %h", a));
	endtask

	// Point at a channel and sample, then read the sample port
	task automatic samp(input logic [2:0] ch, input logic [4:0] s, input logic [7:0] exp);
		wreg(8'h5c, {ch, s});
		rchk(8'h60, exp);
	endtask

	// Lets the edge's updates land before outputs are looked at
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic do_reset();
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
	endtask

	task automatic t_reset();
		for (int i = 8'h48; i <= 8'h5c; i += 4) begin
			rchk(i[7:0], 8'h00);
		end
		chk(irqN, 1'b1, "irq after reset");
		chk(txDriverHighZ, 8'h00, "high-z after reset");
		rchk(8'hfc, 8'h00); // unmapped place reads zero
		samp(3'd0, 5'd3, 8'h00);
		$display("test reset done");
	endtask

	task automatic t_highz();
		wreg(8'h48, 8'ha5);
		tick(1);
		chk(txDriverHighZ, 8'ha5, "high-z pattern");
		rchk(8'h48, 8'ha5);
		wreg(8'h48, 8'h5a);
		tick(1);
		chk(txDriverHighZ, 8'h5a, "high-z inverse");
		$display("test high-z done");
	endtask

	task automatic t_alarm();
		wreg(8'h50, 8'h05);
		@(posedge clk);
		alarmDetect <= 8'h03;
		tick(2);
		chk(irqN, 1'b0, "irq on enabled change");
		rchk(8'h4c, 8'h03);
		@(posedge clk);
		alarmDetect <= 8'h06;
		tick(2);
		rchk(8'h54, 8'h05);
		tick(1);
		chk(irqN, 1'b1, "irq after flag read");
		rchk(8'h54, 8'h00);
		// Earlier change on a masked channel must not appear once enabled
		wreg(8'h50, 8'h07);
		rchk(8'h54, 8'h00);
		@(posedge clk);
		alarmDetect <= 8'h04;
		tick(2);
		chk(irqN, 1'b0, "irq on falling status");
		wreg(8'h80, 8'h02);
		tick(1);
		chk(irqN, 1'b1, "irq after clear write");
		rchk(8'h54, 8'h00);
		$display("test alarm done");
	endtask

	task automatic t_wave();
		wreg(8'h58, 8'h81);
		wreg(8'h5c, 8'h03);
		wreg(8'h60, 8'h3f);
		wreg(8'h58, 8'h00);
		samp(3'd0, 5'd3, 8'h3f);
		samp(3'd7, 5'd3, 8'h3f);
		samp(3'd1, 5'd3, 8'h00);
		wreg(8'h5c, {3'd2, 5'd23});
		wreg(8'h60, 8'h40);
		samp(3'd2, 5'd23, 8'h40);
		samp(3'd3, 5'd23, 8'h00);
		samp(3'd2, 5'd22, 8'h00);
		$display("test waveform done");
	endtask

	task automatic t_soft();
		wreg(8'h48, 8'hff);
		wreg(8'h58, 8'h0f);
		wreg(8'h84, 8'h01);
		rchk(8'h48, 8'h00);
		chk(txDriverHighZ, 8'h00, "high-z after soft reset");
		rchk(8'h50, 8'h00);
		rchk(8'h58, 8'h00);
		samp(3'd2, 5'd23, 8'h40);
		do_reset();
		samp(3'd2, 5'd23, 8'h00);
		$display("test soft reset done");
	endtask

	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		rd = 1'b0;
		wr = 1'b0;
		addr = 8'h00;
		wdata = 32'h0;
		alarmDetect = 8'h00;
		fails = 0;
		check_count = 0;
		do_reset();
		t_reset();
		t_highz();
		t_alarm();
		t_wave();
		t_soft();
		stop_test();
	end
endmodule
